// >>> frc_host_model.sv
// Host serial controller model that frames commands for the block.
`timescale 1ns/100ps
module frc_host_model (
  // Serial pins
  output logic            spiClk,
  output logic            csN,
  output logic      [3:0] hostIo,
  input  wire logic [3:0] ioOut
);
  initial begin
    spiClk = 1'b0;
    csN    = 1'b1;
    hostIo = 4'h0;
  end

  // Frames can end mid-byte (nBits need not be a multiple of 8); released lines get the inverse level.
  task automatic xfer(input bit q, input logic [7:0] op,
                      input logic [31:0] d, input int nBits,
                      input int nRd, output logic [31:0] rd);
    logic [39:0] sh;
    int          w;
    int          k;
    w   = q ? 4 : 1;
    sh  = {op, d};
    rd  = 32'h0;
    csN = 1'b0;
    #7.5;
    for (k = 0; k < (8 + nBits + 8 * nRd) / w; k++) begin
      if (k * w < 8 + nBits) begin
        hostIo = q ? sh[39:36] : {~hostIo[3:1], sh[39]};
        sh = sh << w;
      end else begin
        hostIo = ~hostIo;
        rd = q ? {rd[27:0], ioOut} : {rd[30:0], ioOut[1]};
      end
      #7.5 spiClk = 1'b1;
      #7.5 spiClk = 1'b0;
    end
    #7.5 csN = 1'b1;
    hostIo = ~hostIo;
    #160;
  endtask : xfer
endmodule : frc_host_model

// >>> frc_params.svh
// Opcodes, field positions, reset values and timing for the register block.
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH

`define FRC_OP_RD_SR1      8'h05
`define FRC_OP_RD_SR2      8'h07
`define FRC_OP_RD_CR1      8'h35
`define FRC_OP_RD_CR2      8'h15
`define FRC_OP_RD_CR3      8'h33
`define FRC_OP_REG_WRITE   8'h01
`define FRC_OP_WR_EN       8'h06
`define FRC_OP_VOL_WR_EN   8'h50
`define FRC_OP_CLR_STATUS  8'h30

`define FRC_SR1_BUSY_BIT   0
`define FRC_SR1_LATCH_BIT  1
`define FRC_SR1_PROT_BIT   7
`define FRC_SR2_PERR_BIT   5
`define FRC_SR2_EERR_BIT   6
`define FRC_CR1_QUAD_BIT   1
`define FRC_CR2_FOURBIT    3

`define FRC_SR1_RST        8'h00
`define FRC_SR2_RST        8'h00
`define FRC_CR1_RST        8'h00
`define FRC_CR2_RST        8'h00
`define FRC_CR3_RST        8'h00

`define FRC_OP_BITS        7'h08
`define FRC_MAX_BITS       7'h28
`define FRC_SYS_MHZ        50
`define FRC_NV_WRITE_NS    200000

`endif

// >>> frc_pkg.sv
// Types shared by the flash register command block.
package frc_pkg;

  typedef logic [7:0] frc_byte_t;

  typedef struct packed {
    frc_byte_t sr1;
    frc_byte_t sr2;
    frc_byte_t cr1;
    frc_byte_t cr2;
    frc_byte_t cr3;
  } frc_regs_s;

  typedef struct packed {
    logic        seq;
    frc_byte_t   opcode;
    logic [31:0] data;
    logic [6:0]  bits;
  } frc_frame_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WRITE = 2'h1,
    ST_FAIL  = 2'h3
  } frc_state_e;

  typedef enum logic [2:0] {
    SEL_SR1 = 3'h0,
    SEL_SR2 = 3'h1,
    SEL_CR1 = 3'h2,
    SEL_CR2 = 3'h3,
    SEL_CR3 = 3'h4
  } frc_sel_e;

  typedef struct packed {
    logic [6:0] cnt;
    frc_byte_t  acc;
    frc_byte_t  shOut;
    frc_sel_e   sel;
    logic       reading;
    logic       wide;
    logic       reqS1;
    logic       reqS2;
    logic       ack;
    frc_regs_s  mirror;
    frc_frame_s frame;
  } frc_link_s;

  typedef struct packed {
    logic        csS1;
    logic        csS2;
    logic        csS3;
    logic        ackS1;
    logic        ackS2;
    logic        rstS1;
    logic        rstS2;
    logic        wpS1;
    logic        wpS2;
    logic        reqTgl;
    logic        seenSeq;
    logic        volEn;
    frc_state_e  state;
    logic [23:0] timer;
    frc_regs_s   pub;
    frc_regs_s   vol;
    frc_regs_s   nv;
    frc_regs_s   pend;
  } frc_sys_s;

endpackage : frc_pkg

// >>> frc_register_access.sv
// Status and configuration register commands of a serial NOR flash.
`timescale 1ns/100ps
`include "frc_params.svh"
module frc_register_access
  import frc_pkg::*;
#(
  parameter int NV_WRITE_CYC =
    (`FRC_NV_WRITE_NS * `FRC_SYS_MHZ + 999) / 1000
)
(
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Serial link
  input  wire logic       spiClk,
  input  wire logic       csN,
  input  wire logic [3:0] ioIn,
  output logic      [3:0] ioOut,
  output logic      [3:0] ioOe,
  // Protect and reset pins
  input  wire logic       wpN,
  input  wire logic       hwResetN,
  // Array side
  input  wire logic       softResetReq,
  input  wire logic       nvEraseFail,
  input  wire logic       nvProgFail,
  // Register views
  output frc_regs_s       volRegs,
  output frc_regs_s       nvRegs,
  output logic            busy
);
  localparam frc_regs_s REGS_RST = '{
    sr1: `FRC_SR1_RST,
    sr2: `FRC_SR2_RST,
    cr1: `FRC_CR1_RST,
    cr2: `FRC_CR2_RST,
    cr3: `FRC_CR3_RST
  };
  localparam logic [23:0] WRITE_LAST = 24'(NV_WRITE_CYC - 1);

  frc_sys_s   q;
  frc_sys_s   d;
  frc_frame_s frame;
  logic       pubAckTgl;
  logic       frameEnd;
  logic       resetHit;
  logic       pinProtect;
  logic       lenOk;
  logic [2:0] nBytes;
  logic       enabled;
  logic       isEight;

  // Only the written bytes change; busy and latch bits are not writable.
  function automatic frc_regs_s applyWrite(
    frc_regs_s   r,
    logic [31:0] v,
    logic [2:0]  n
  );
    frc_regs_s w;
    w = r;
    w.sr1[7:2] = v[7:2];
    if (n > 3'h1) begin
      w.cr1 = v[15:8];
    end
    if (n > 3'h2) begin
      w.cr2 = v[23:16];
    end
    if (n > 3'h3) begin
      w.cr3 = v[31:24];
    end
    return w;
  endfunction : applyWrite

  // Copy of the non-volatile set into the volatile set, keeping flags.
  function automatic frc_regs_s loadVolatile(
    frc_regs_s v,
    frc_regs_s nv
  );
    frc_regs_s w;
    w = v;
    w.sr1[7:2] = nv.sr1[7:2];
    w.cr1      = nv.cr1;
    w.cr2      = nv.cr2;
    w.cr3      = nv.cr3;
    return w;
  endfunction : loadVolatile

  frc_spi_link u_link (
    .srst      (srst),
    .spiClk    (spiClk),
    .csN       (csN),
    .ioIn      (ioIn),
    .ioOut     (ioOut),
    .ioOe      (ioOe),
    .pubRegs   (q.pub),
    .pubReqTgl (q.reqTgl),
    .pubAckTgl (pubAckTgl),
    .frame     (frame)
  );

  always_comb begin
    d = q;

    d.csS1  = csN;
    d.csS2  = q.csS1;
    d.csS3  = q.csS2;
    d.ackS1 = pubAckTgl;
    d.ackS2 = q.ackS1;
    d.rstS1 = hwResetN;
    d.rstS2 = q.rstS1;
    d.wpS1  = wpN;
    d.wpS2  = q.wpS1;

    // The link clock is idle once chip select is high, so the frame
    // words are stable by the time the synchronised rise is seen. The
    // sequence bit keeps a deselect without clocks from replaying the
    // previous frame.
    frameEnd = q.csS2 & ~q.csS3 & (frame.seq != q.seenSeq);
    if (frameEnd) begin
      d.seenSeq = frame.seq;
    end

    resetHit = ~q.rstS2 | softResetReq;
    pinProtect = q.vol.sr1[`FRC_SR1_PROT_BIT]
               & ~q.wpS2
               & ~q.vol.cr1[`FRC_CR1_QUAD_BIT]
               & ~q.vol.cr2[`FRC_CR2_FOURBIT];
    lenOk   = (frame.bits == 7'h10) | (frame.bits == 7'h18)
            | (frame.bits == 7'h20) | (frame.bits == `FRC_MAX_BITS);
    nBytes  = 3'(frame.bits[5:3] - 3'h1);
    isEight = frame.bits == `FRC_OP_BITS;
    enabled = q.vol.sr1[`FRC_SR1_LATCH_BIT] | q.volEn;

    // New snapshot for the link only after the last one was taken.
    if (q.ackS2 == q.reqTgl) begin
      d.pub    = q.vol;
      d.reqTgl = ~q.reqTgl;
    end

    case (q.state)
      ST_IDLE: begin
        if (frameEnd) begin
          case (frame.opcode)
            `FRC_OP_WR_EN: begin
              if (isEight) begin
                d.vol.sr1[`FRC_SR1_LATCH_BIT] = 1'h1;
                d.volEn = 1'h0;
              end
            end
            `FRC_OP_VOL_WR_EN: begin
              if (isEight) begin
                d.volEn = 1'h1;
              end
            end
            `FRC_OP_REG_WRITE: begin
              if (enabled && lenOk) begin
                if (pinProtect) begin
                  // Dropped without an error flag; enables stay as
                  // they were.
                  d.volEn = q.volEn;
                end else if (q.volEn) begin
                  d.vol = applyWrite(q.vol, frame.data,
                                     nBytes);
                  d.vol.sr1[`FRC_SR1_LATCH_BIT] = 1'h0;
                  d.volEn = 1'h0;
                end else begin
                  d.pend  = applyWrite(q.nv, frame.data,
                                       nBytes);
                  d.timer = WRITE_LAST;
                  d.state = ST_WRITE;
                end
              end
            end
            default: begin
              d.volEn = q.volEn;
            end
          endcase
        end else if (resetHit) begin
          d.vol = loadVolatile(q.vol, q.nv);
          d.vol.sr1[`FRC_SR1_LATCH_BIT] = 1'h0;
          d.volEn = 1'h0;
        end
      end
      ST_WRITE: begin
        // Reset requests are not looked at in this state.
        if (q.timer != 24'h0) begin
          d.timer = q.timer - 24'h1;
        end else if (nvEraseFail) begin
          d.vol.sr2[`FRC_SR2_EERR_BIT] = 1'h1;
          d.state = ST_FAIL;
        end else if (nvProgFail) begin
          d.vol.sr2[`FRC_SR2_PERR_BIT] = 1'h1;
          d.state = ST_FAIL;
        end else begin
          // Erase and program form one step; the result is then copied
          // into the volatile set.
          d.nv    = q.pend;
          d.vol   = loadVolatile(q.vol, q.pend);
          d.vol.sr1[`FRC_SR1_LATCH_BIT] = 1'h0;
          d.state = ST_IDLE;
        end
      end
      ST_FAIL: begin
        d.state = ST_FAIL;
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Clear status is taken in every state.
    if (frameEnd && isEight && frame.opcode == `FRC_OP_CLR_STATUS) begin
      d.vol.sr1[`FRC_SR1_LATCH_BIT] = 1'h0;
      // An error raised by the engine in this very cycle wins.
      if (q.state != ST_WRITE) begin
        d.vol.sr2[`FRC_SR2_PERR_BIT] = 1'h0;
        d.vol.sr2[`FRC_SR2_EERR_BIT] = 1'h0;
      end
      if (q.state == ST_FAIL) begin
        d.state = ST_IDLE;
      end
    end

    d.vol.sr1[`FRC_SR1_BUSY_BIT] = (d.state != ST_IDLE);

    if (srst) begin
      d       = '0;
      d.csS1  = 1'h1;
      d.csS2  = 1'h1;
      d.csS3  = 1'h1;
      d.rstS1 = 1'h1;
      d.rstS2 = 1'h1;
      d.wpS1  = 1'h1;
      d.wpS2  = 1'h1;
      d.state = ST_IDLE;
      d.pub   = REGS_RST;
      d.vol   = REGS_RST;
      d.nv    = REGS_RST;
      d.pend  = REGS_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign volRegs = q.vol;
  assign nvRegs  = q.nv;
  assign busy    = (q.state != ST_IDLE);

endmodule : frc_register_access

// >>> frc_register_access_sva.sv
// Concurrent checks on the ports of the register command block.
`timescale 1ns/100ps
module frc_register_access_sva
  import frc_pkg::*;
#(
  parameter int NV_WRITE_CYC = 10000
)
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // Serial link
  input wire logic       spiClk,
  input wire logic       csN,
  input wire logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  // Pins and array side
  input wire logic       wpN,
  input wire logic       hwResetN,
  input wire logic       softResetReq,
  input wire logic       nvEraseFail,
  input wire logic       nvProgFail,
  // Register views
  input wire frc_regs_s  volRegs,
  input wire frc_regs_s  nvRegs,
  input wire logic       busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_oeIdle;
    csN |-> ioOe == 4'h0;
  endproperty
  property p_oeMode;
    ioOe inside {4'h0, 4'h2, 4'hF};
  endproperty
  property p_oeHold;
    (!csN && ioOe != 4'h0) ##1 !csN |-> $stable(ioOe);
  endproperty
  property p_wipRise;
    $rose(busy) |-> volRegs.sr1[0];
  endproperty
  property p_fallClr;
    $fell(busy) |-> volRegs.sr1[1:0] == 2'h0;
  endproperty
  // A reset pin or request must not cut a running write short.
  property p_busyMin;
    $rose(busy) |-> busy[*8];
  endproperty
  property p_errBusy;
    volRegs.sr2[6:5] != 2'h0 |-> busy;
  endproperty
  property p_nvEnd;
    $changed(nvRegs) |-> $past(busy);
  endproperty

  a_oeIdle: assert property (p_oeIdle) else $error("oe when idle");
  a_oeMode: assert property (p_oeMode) else $error("bad oe");
  a_oeHold: assert property (p_oeHold) else $error("oe moved");
  a_wipRise: assert property (p_wipRise) else $error("no wip");
  a_fallClr: assert property (p_fallClr) else $error("flags kept");
  a_busyMin: assert property (p_busyMin) else $error("short");
  a_errBusy: assert property (p_errBusy) else $error("err idle");
  a_nvEnd: assert property (p_nvEnd) else $error("nv moved");

  c_done: cover property ($fell(busy));
  c_err: cover property (volRegs.sr2[6]);
  c_quad: cover property (ioOe == 4'hF);
endmodule : frc_register_access_sva

bind frc_register_access frc_register_access_sva #(
  .NV_WRITE_CYC(NV_WRITE_CYC)
) i_frc_register_access_sva (
  .sys_clk(sys_clk), .srst(srst), .spiClk(spiClk), .csN(csN),
  .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .wpN(wpN),
  .hwResetN(hwResetN), .softResetReq(softResetReq),
  .nvEraseFail(nvEraseFail), .nvProgFail(nvProgFail),
  .volRegs(volRegs), .nvRegs(nvRegs), .busy(busy)
);

// >>> frc_spi_link.sv
// Serial link front end: shifts frames in and register bytes out.
`timescale 1ns/100ps
`include "frc_params.svh"
module frc_spi_link
  import frc_pkg::*;
(
  // Reset from the system side
  input  wire logic       srst,
  // Serial pins
  input  wire logic       spiClk,
  input  wire logic       csN,
  input  wire logic [3:0] ioIn,
  output logic      [3:0] ioOut,
  output logic      [3:0] ioOe,
  // Register snapshot handshake
  input  wire frc_regs_s  pubRegs,
  input  wire logic       pubReqTgl,
  output logic            pubAckTgl,
  // Last frame, stable while the link clock stands still
  output frc_frame_s      frame
);
  frc_link_s  q;
  frc_link_s  d;
  logic       startQ;
  logic       wide;
  logic [6:0] base;
  logic [6:0] cntN;
  logic [1:0] slot;
  frc_byte_t  accN;
  frc_sel_e   sel;
  logic       hit;

  function automatic frc_byte_t pick(frc_sel_e s, frc_regs_s r);
    case (s)
      SEL_SR2: pick = r.sr2;
      SEL_CR1: pick = r.cr1;
      SEL_CR2: pick = r.cr2;
      SEL_CR3: pick = r.cr3;
      default: pick = r.sr1;
    endcase
  endfunction : pick

  always_comb begin
    d    = q;
    // The lane width is frozen at the first edge of a frame.
    wide = startQ ? q.mirror.cr2[`FRC_CR2_FOURBIT] : q.wide;
    base = startQ ? 7'h00 : q.cnt;
    accN = wide ? {q.acc[3:0], ioIn} : {q.acc[6:0], ioIn[0]};
    // Past 64 bits the count wraps with its top bit held, so long polls
    // keep finding byte boundaries while the frame length reads invalid.
    cntN = base[6] ? {1'h1, 6'(base[5:0] + (wide ? 6'h04 : 6'h01))}
                   : base + (wide ? 7'h04 : 7'h01);
    slot = 2'(cntN[5:3] - 3'h2);
    sel  = SEL_SR1;
    hit  = 1'h0;
    d.wide    = wide;
    d.acc     = accN;
    d.cnt     = cntN;
    d.shOut   = wide ? {q.shOut[3:0], 4'h0} : {q.shOut[6:0], 1'h0};
    if (startQ) begin
      d.reading   = 1'h0;
      d.frame     = '0;
      d.frame.seq = ~q.frame.seq;
    end
    if (cntN[2:0] == 3'h0) begin
      if (cntN == `FRC_OP_BITS) begin
        case (accN)
          `FRC_OP_RD_SR1: begin
            sel = SEL_SR1;
            hit = 1'h1;
          end
          `FRC_OP_RD_SR2: begin
            sel = SEL_SR2;
            hit = ~wide;
          end
          `FRC_OP_RD_CR1: begin
            sel = SEL_CR1;
            hit = ~wide;
          end
          `FRC_OP_RD_CR2: begin
            sel = SEL_CR2;
            hit = ~wide;
          end
          `FRC_OP_RD_CR3: begin
            sel = SEL_CR3;
            hit = ~wide;
          end
          default: begin
            sel = SEL_SR1;
            hit = 1'h0;
          end
        endcase
        d.frame.opcode = accN;
        d.reading      = hit;
        d.sel          = sel;
      end else if (cntN <= `FRC_MAX_BITS) begin
        d.frame.data[8*slot +: 8] = accN;
      end
      // Every byte boundary reloads a fresh copy of the register.
      if (d.reading) begin
        d.shOut = pick(d.sel, q.mirror);
      end
    end
    d.frame.bits = cntN;
    d.reqS1 = pubReqTgl;
    d.reqS2 = q.reqS1;
    if (q.reqS2 != q.ack) begin
      d.mirror = pubRegs;
      d.ack    = ~q.ack;
    end
  end

  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      startQ <= 1'h1;
    end else begin
      startQ <= 1'h0;
    end
  end

  always_ff @(posedge spiClk or posedge srst) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ioOut     = q.wide ? q.shOut[7:4] : {2'h0, q.shOut[7], 1'h0};
  // The read flag of the last frame lives until the first edge of the
  // next one, so the start marker keeps the pins released meanwhile.
  assign ioOe      = (q.reading & ~csN & ~startQ)
                   ? (q.wide ? 4'hF : 4'h2) : 4'h0;
  assign pubAckTgl = q.ack;
  assign frame     = q.frame;

endmodule : frc_spi_link

// >>> tb.sv
// Self-checking bench for the register command block.
`timescale 1ns/100ps
module tb;
  import frc_pkg::*;
  localparam int NvCyc = 60;
  logic sys_clk, srst, spiClk, csN, wpN, hwResetN, softResetReq;
  logic nvEraseFail, nvProgFail, busy;
  logic [3:0] ioIn, ioOut, ioOe, hostIo;
  frc_regs_s volRegs, nvRegs;
  logic [31:0] rd;
  logic [7:0] ex [4];
  logic [7:0] rEx [5];
  logic [7:0] rOp [5] = '{8'h05, 8'h07, 8'h35, 8'h15, 8'h33};
  int error_cnt = 0;
  int comparisons = 0;
  int k, n;

  assign ioIn = (ioOe & ioOut) | (~ioOe & hostIo);

  frc_register_access #(.NV_WRITE_CYC(NvCyc)) i_frc_register_access (
    .sys_clk(sys_clk), .srst(srst), .spiClk(spiClk), .csN(csN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .wpN(wpN),
    .hwResetN(hwResetN), .softResetReq(softResetReq),
    .nvEraseFail(nvEraseFail), .nvProgFail(nvProgFail),
    .volRegs(volRegs), .nvRegs(nvRegs), .busy(busy));
  frc_host_model i_frc_host_model (
    .spiClk(spiClk), .csN(csN), .hostIo(hostIo), .ioOut(ioOut));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input bit q, input logic [7:0] op,
                    input logic [31:0] d, input int nb);
    i_frc_host_model.xfer(q, op, d, nb, 0, rd);
  endtask : wr

  // Polls several bytes; early ones may still hold an older snapshot.
  task automatic rdc(input bit q, input logic [7:0] op,
                     input logic [7:0] exp);
    i_frc_host_model.xfer(q, op, 32'h0, 0, q ? 8 : 3, rd);
    chk(rd[15:8], exp);
    chk(rd[7:0], exp);
  endtask : rdc

  task automatic chkAll;
    chk(volRegs.sr1, ex[0]);
    chk(volRegs.cr1, ex[1]);
    chk(volRegs.cr2, ex[2]);
    chk(volRegs.cr3, ex[3]);
  endtask : chkAll

  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end

  initial begin
    {srst, wpN, hwResetN} = 3'h7;
    {softResetReq, nvEraseFail, nvProgFail} = 3'h0;
    repeat (12) tick;
    srst = 1'b0;
    repeat (8) tick;
    for (k = 0; k < 5; k++) begin
      chk(volRegs[8*k+:8], 8'h00);
      chk(nvRegs[8*k+:8], 8'h00);
    end
    for (n = 1; n <= 4; n++) begin
      for (k = 0; k < n; k++) ex[k] = {n[2:0], k[1:0], 3'h0};
      wr(0, 8'h50, 32'h0, 0);
      wr(0, 8'h01, {ex[0], ex[1], ex[2], ex[3]}, 8 * n);
      chkAll;
      chk(nvRegs.sr1, 8'h00);
    end
    wr(0, 8'h50, 32'h0, 0);
    wr(0, 8'h01, 32'hFFFF_FFFF, 12);
    chkAll;
    rEx = '{ex[0], 8'h00, ex[1], ex[2], ex[3]};
    for (k = 0; k < 5; k++) rdc(0, rOp[k], rEx[k]);
    wr(0, 8'h06, 32'h0, 0);
    chk(volRegs.sr1, 8'h82);
    wr(0, 8'h01, 32'h1C00_0000, 8);
    tick;
    {hwResetN, softResetReq} = 2'h1;
    rdc(0, 8'h05, 8'h83);
    chk(volRegs.cr3, ex[3]);
    {hwResetN, softResetReq} = 2'h2;
    for (k = 0; k < NvCyc + 50 && busy !== 1'b0; k++) tick;
    chk(nvRegs.sr1, 8'h1C);
    chk(volRegs.sr1, 8'h1C);
    rdc(0, 8'h05, 8'h1C);
    for (n = 0; n < 2; n++) begin
      tick;
      {nvEraseFail, nvProgFail} = n ? 2'h1 : 2'h2;
      wr(0, 8'h06, 32'h0, 0);
      wr(0, 8'h01, 32'h1C00_0000, 8);
      repeat (NvCyc + 20) tick;
      chk(volRegs.sr2, n ? 8'h20 : 8'h40);
      chk({7'h0, busy}, 8'h01);
      wr(0, 8'h30, 32'h0, 0);
      chk(volRegs.sr2, 8'h00);
      chk({5'h0, busy, volRegs.sr1[1:0]}, 8'h00);
    end
    {nvEraseFail, nvProgFail} = 2'h0;
    wr(0, 8'h50, 32'h0, 0);
    wr(0, 8'h01, 32'h8000_0000, 8);
    tick;
    wpN = 1'b0;
    wr(0, 8'h50, 32'h0, 0);
    wr(0, 8'h01, 32'h0400_0000, 8);
    chk(volRegs.sr1, 8'h80);
    chk(volRegs.sr2, 8'h00);
    tick;
    wpN = 1'b1;
    wr(0, 8'h01, 32'h0400_0000, 8);
    chk(volRegs.sr1, 8'h04);
    tick;
    wpN = 1'b0;
    wr(0, 8'h50, 32'h0, 0);
    wr(0, 8'h01, 32'h8000_0800, 24);
    chk(volRegs.cr2, 8'h08);
    rdc(0, 8'h15, 8'h08);
    wr(1, 8'h50, 32'h0, 0);
    wr(1, 8'h01, 32'h3C00_0000, 8);
    chk(volRegs.sr1, 8'h3C);
    rdc(1, 8'h05, 8'h3C);
    wrap_up;
  end
endmodule : tb
